//--- src/pxl_ctrl.sv
// pxl_ctrl: crossover, diagnostics, error-count select and loopback control registers.
// Assumes a management front end gives a one-cycle read or write strobe with register address,
// and the transceiver core supplies error pulses, detected wiring and link state on this clock.
//
// Functional notes
// - auto crossover bit 10, reset one
// - manual bit 9 picks MDI or MDI-X
// - manual bit ignored under automatic crossover
// - third/fourth pair swap always corrected
// - pair mapping per wiring only, same at every speed
// - diagnostics enable bit 2, reset zero
// - select bits choose counted error kinds
// - bits 14 and 13 select counter source
// - 16-bit error counter, read only, clear-on-read
// - bit 15 selects MII loopback
// - bit 12 all-digital loopback, reset one
// - bit 10 line driver, 9 remote
// - bit 7 external cable loopback
// - bit 6 suppresses transmit in digital loopback
// - bit 0 forces link in MII loopback
// - other loopbacks report real link state
`timescale 1ns/1ns
module pxl_ctrl (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire logic general_loopback,
	input wire logic [1:0] speed,
	input wire logic detected_mdix,
	input wire logic detected_pair_swap,
	input wire logic link_up,
	input wire logic crc_err,
	input wire logic symbol_err,
	input wire logic false_carrier,
	output logic wiring_mdix,
	output logic pair_swap_cd,
	output logic [1:0] tx_pair_sel,
	output logic [1:0] rx_pair_sel,
	output logic diag_enable,
	output logic resolve_before_force,
	output logic mii_loopback,
	output logic digital_loopback,
	output logic line_driver_loopback,
	output logic remote_loopback,
	output logic ext_cable_loopback,
	output logic tx_suppress,
	output logic link_status,
	output logic loopback_setup_error
);
	logic [15:0] ctrl_two_reg;
	logic [15:0] ctrl_two_next;
	logic [15:0] loop_reg;
	logic [15:0] loop_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic [1:0] tx_sel_reg;
	logic [1:0] tx_sel_next;
	logic [1:0] rx_sel_reg;
	logic [1:0] rx_sel_next;
	logic mdix_reg;
	logic mdix_next;
	logic swap_reg;
	logic swap_next;
	logic link_reg;
	logic link_next;
	logic any_loop;
	logic want_gen;
	pxl_err_if err ();

	assign err.crc_err = crc_err;
	assign err.symbol_err = symbol_err;
	assign err.false_carrier = false_carrier;
	assign err.count_false_carrier = ctrl_two_reg[pxl_pkg::CT_FALSE_CARRIER_BIT];
	assign err.count_symbol = ctrl_two_reg[pxl_pkg::CT_SYMBOL_BIT];
	assign err.read_clear = mgmt_rd && mgmt_addr == pxl_pkg::ADDR_RX_ERR;

	pxl_err_counter #(.WIDTH(16)) u_err_counter (
		.clock(clock),
		.sys_rst(sys_rst),
		.err(err)
	);

	always_comb begin
		ctrl_two_next = ctrl_two_reg;
		loop_next = loop_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (mgmt_wr && mgmt_addr == pxl_pkg::ADDR_CTRL_TWO) begin
			ctrl_two_next = mgmt_wdata & pxl_pkg::CT_WRITE_MASK;
		end else if (mgmt_wr && mgmt_addr == pxl_pkg::ADDR_LOOPBACK) begin
			loop_next = mgmt_wdata & pxl_pkg::LB_WRITE_MASK;
		end
		if (mgmt_rd) begin
			rvalid_next = 1'b1;
			if (mgmt_addr == pxl_pkg::ADDR_CTRL_TWO) begin
				rdata_next = ctrl_two_reg;
			end else if (mgmt_addr == pxl_pkg::ADDR_LOOPBACK) begin
				rdata_next = loop_reg;
			end else if (mgmt_addr == pxl_pkg::ADDR_RX_ERR) begin
				rdata_next = err.count;
			end else begin
				rdata_next = 16'h0000;
			end
		end
	end

	always_comb begin
		if (ctrl_two_reg[pxl_pkg::CT_AUTO_XOVER_BIT]) begin
			mdix_next = detected_mdix;
		end else begin
			mdix_next = ctrl_two_reg[pxl_pkg::CT_MANUAL_X_BIT];
		end
		swap_next = detected_pair_swap;
		// slow speeds: one pair sends, the other receives; gigabit uses all pairs both ways,
		// channel A/B on the first two pairs, so the selects name the pair that carries channel A
		tx_sel_next = mdix_next ? 2'h1 : 2'h0;
		rx_sel_next = mdix_next ? 2'h0 : 2'h1;
		if (speed == 2'h2 && mdix_next) begin
			tx_sel_next = 2'h1;
			rx_sel_next = 2'h0;
		end
	end

	assign any_loop = loop_reg[pxl_pkg::LB_MII_BIT] | loop_reg[pxl_pkg::LB_DIGITAL_BIT] |
		loop_reg[pxl_pkg::LB_LINE_DRIVER_BIT] | loop_reg[pxl_pkg::LB_REMOTE_BIT] |
		loop_reg[pxl_pkg::LB_EXT_CABLE_BIT];
	// general loopback bit required for near-end modes
	assign want_gen = loop_reg[pxl_pkg::LB_MII_BIT] | loop_reg[pxl_pkg::LB_DIGITAL_BIT] |
		loop_reg[pxl_pkg::LB_LINE_DRIVER_BIT];

	always_comb begin
		if (general_loopback && loop_reg[pxl_pkg::LB_MII_BIT]) begin
			link_next = loop_reg[pxl_pkg::LB_FORCE_LINK_BIT];
		end else begin
			link_next = link_up;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_two_reg <= pxl_pkg::CT_RESET;
			loop_reg <= pxl_pkg::LB_RESET;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
			mdix_reg <= 1'b0;
			swap_reg <= 1'b0;
			tx_sel_reg <= 2'h0;
			rx_sel_reg <= 2'h1;
			link_reg <= 1'b0;
		end else begin
			ctrl_two_reg <= ctrl_two_next;
			loop_reg <= loop_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			mdix_reg <= mdix_next;
			swap_reg <= swap_next;
			tx_sel_reg <= tx_sel_next;
			rx_sel_reg <= rx_sel_next;
			link_reg <= link_next;
		end
	end

	assign mgmt_rdata = rdata_reg;
	assign mgmt_rvalid = rvalid_reg;
	assign wiring_mdix = mdix_reg;
	assign pair_swap_cd = swap_reg;
	assign tx_pair_sel = tx_sel_reg;
	assign rx_pair_sel = rx_sel_reg;
	assign diag_enable = ctrl_two_reg[pxl_pkg::CT_DIAG_BIT];
	assign resolve_before_force = ctrl_two_reg[pxl_pkg::CT_RESOLVE_BIT];
	assign mii_loopback = loop_reg[pxl_pkg::LB_MII_BIT] & general_loopback;
	assign digital_loopback = loop_reg[pxl_pkg::LB_DIGITAL_BIT] & general_loopback;
	assign line_driver_loopback = loop_reg[pxl_pkg::LB_LINE_DRIVER_BIT] & general_loopback;
	assign remote_loopback = loop_reg[pxl_pkg::LB_REMOTE_BIT] & ~general_loopback;
	assign ext_cable_loopback = loop_reg[pxl_pkg::LB_EXT_CABLE_BIT] & ~general_loopback;
	assign tx_suppress = digital_loopback & loop_reg[pxl_pkg::LB_TX_SUPPRESS_BIT];
	assign link_status = link_reg;
	// flags a host misconfiguration, does not block it
	assign loopback_setup_error = general_loopback & any_loop & ~want_gen;
endmodule

//--- src/pxl_err_counter.sv
// pxl_err_counter: 16-bit receive error counter, saturating, cleared on read.
// Assumes event inputs are single-cycle pulses already in the clock domain.
`timescale 1ns/1ns
module pxl_err_counter #(
	parameter int WIDTH = 16
) (
	input wire logic clock,
	input wire logic sys_rst,
	pxl_err_if.cnt err
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic hit;
	always_comb begin
		// source choice: false carrier adds to either base kind
		hit = (err.count_symbol ? err.symbol_err : err.crc_err) | (err.count_false_carrier & err.false_carrier);
		count_next = count_reg;
		// an event in the read cycle is kept: the read returns the old value, the counter restarts at one
		if (err.read_clear) begin
			count_next = hit ? WIDTH'(1) : '0;
		end else if (hit && count_reg != '1) begin
			count_next = count_reg + WIDTH'(1);
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
	assign err.count = 16'(count_reg);
endmodule

//--- src/pxl_err_if.sv
// pxl_err_if: error events and read-clear between the control block and its
// receive error counter. Single clock domain.
`timescale 1ns/1ns
interface pxl_err_if;
	logic crc_err;
	logic symbol_err;
	logic false_carrier;
	logic count_false_carrier;
	logic count_symbol;
	logic read_clear;
	logic [15:0] count;
	modport ctrl (output crc_err, output symbol_err, output false_carrier, output count_false_carrier,
		output count_symbol, output read_clear, input count);
	modport cnt (input crc_err, input symbol_err, input false_carrier, input count_false_carrier,
		input count_symbol, input read_clear, output count);
endinterface

//--- src/pxl_pkg.sv
// pxl_pkg: register offsets, field positions and reset values for the
// crossover and loopback control block. Assumes a 5-bit management register address.
package pxl_pkg;
	localparam logic [4:0] ADDR_CTRL_TWO = 5'h12;
	localparam logic [4:0] ADDR_LOOPBACK = 5'h13;
	localparam logic [4:0] ADDR_RX_ERR = 5'h14;
	// second control register fields
	localparam int CT_RESOLVE_BIT = 15;
	localparam int CT_FALSE_CARRIER_BIT = 14;
	localparam int CT_SYMBOL_BIT = 13;
	localparam int CT_AUTO_XOVER_BIT = 10;
	localparam int CT_MANUAL_X_BIT = 9;
	localparam int CT_DIAG_BIT = 2;
	localparam logic [15:0] CT_WRITE_MASK = 16'he604;
	localparam logic [15:0] CT_RESET = 16'h8400;
	// loopback control fields
	localparam int LB_MII_BIT = 15;
	localparam int LB_DIGITAL_BIT = 12;
	localparam int LB_LINE_DRIVER_BIT = 10;
	localparam int LB_REMOTE_BIT = 9;
	localparam int LB_EXT_CABLE_BIT = 7;
	localparam int LB_TX_SUPPRESS_BIT = 6;
	localparam int LB_FORCE_LINK_BIT = 0;
	localparam logic [15:0] LB_WRITE_MASK = 16'h96c1;
	localparam logic [15:0] LB_RESET = 16'h1001;
	typedef enum logic [1:0] {
		PXL_WIRING_MDI = 2'b00,
		PXL_WIRING_MDIX = 2'b01
	} pxl_wiring_t;
endpackage

//--- tb/pxl_ctrl_asserts.sv
// pxl_ctrl_asserts: port-level timing checks for pxl_ctrl.
// assumes one clock and a synchronous active-high reset; bound at the foot.
`timescale 1ns/1ns
module pxl_ctrl_asserts (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic mgmt_rd,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	input wire logic general_loopback,
	input wire logic detected_pair_swap,
	input wire logic link_up,
	input wire logic pair_swap_cd,
	input wire logic [1:0] tx_pair_sel,
	input wire logic [1:0] rx_pair_sel,
	input wire logic mii_loopback,
	input wire logic digital_loopback,
	input wire logic remote_loopback,
	input wire logic ext_cable_loopback,
	input wire logic tx_suppress,
	input wire logic link_status
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	property p_rvalid;
		mgmt_rd |=> mgmt_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_unmapped;
		mgmt_rd && (mgmt_addr < 5'h12 || mgmt_addr > 5'h14) |=> mgmt_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_swap;
		1'b1 |=> pair_swap_cd == $past(detected_pair_swap);
	endproperty
	a_swap: assert property (p_swap) else $error("pair swap not corrected");
	property p_link;
		!mii_loopback |=> link_status == $past(link_up);
	endproperty
	a_link: assert property (p_link) else $error("link status not real link");
	property p_pair;
		tx_pair_sel[0] != rx_pair_sel[0];
	endproperty
	a_pair: assert property (p_pair) else $error("tx and rx on same pair");
	property p_supp;
		tx_suppress |-> digital_loopback;
	endproperty
	a_supp: assert property (p_supp) else $error("suppress outside digital loopback");
	property p_far;
		remote_loopback || ext_cable_loopback |-> !general_loopback;
	endproperty
	a_far: assert property (p_far) else $error("far loopback with general bit");
	property p_mii;
		mii_loopback |-> general_loopback;
	endproperty
	a_mii: assert property (p_mii) else $error("mii loopback without general bit");
	c_mii_link: cover property (mii_loopback && link_status);
	c_supp: cover property (tx_suppress);
	c_remote: cover property (remote_loopback && ext_cable_loopback);
endmodule
bind pxl_ctrl pxl_ctrl_asserts u_pxl_ctrl_asserts (.*);

//--- tb/pxl_host.sv
// pxl_host: management host model issuing single register accesses.
// assumes each task call starts just after a rising clock edge.
`timescale 1ns/1ns
module pxl_host (
	input wire logic clock,
	output logic mgmt_wr,
	output logic mgmt_rd,
	output logic [4:0] mgmt_addr,
	output logic [15:0] mgmt_wdata
);
	initial begin
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_addr = 5'h00;
		mgmt_wdata = 16'h0000;
	end
	// idle cycle after each strobe so back-to-back calls never retouch it at one edge
	task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
		mgmt_wr <= w;
		mgmt_rd <= !w;
		mgmt_addr <= a;
		mgmt_wdata <= d;
		@(posedge clock);
		mgmt_wr <= 1'b0;
		mgmt_rd <= 1'b0;
		mgmt_wdata <= ~d;
		@(posedge clock);
	endtask
endmodule

//--- tb/tb.sv
// tb: self-checking bench for pxl_ctrl driven through the host model.
// assumes pxl_pkg is compiled first.
`timescale 1ns/1ns
module tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic general_loopback = 1'b0, detected_mdix = 1'b0, detected_pair_swap = 1'b0, link_up = 1'b0;
	logic crc_err = 1'b0, symbol_err = 1'b0, false_carrier = 1'b0;
	logic [1:0] speed = 2'h0;
	logic mgmt_wr, mgmt_rd, mgmt_rvalid, wiring_mdix, pair_swap_cd, diag_enable, resolve_before_force;
	logic mii_loopback, digital_loopback, line_driver_loopback, remote_loopback, ext_cable_loopback;
	logic tx_suppress, link_status, loopback_setup_error;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, d, e;
	logic [1:0] tx_pair_sel, rx_pair_sel;
	logic [15:0] expq[$];
	logic [24:0] lbt [5] = '{{2'h2, 16'h8001, 7'h41}, {2'h3, 16'h9440, 7'h72}, {2'h1, 16'h0280, 7'h0d},
		{2'h3, 16'h1000, 7'h21}, {2'h2, 16'h0080, 7'h00}};
	int fails = 0, checked = 0;
	pxl_ctrl DUT (.*);
	pxl_host host (.*);
	always #5 clock = ~clock;
	task automatic cmp(input logic [15:0] g, input logic [15:0] x);
		checked++;
		if (g !== x) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic conclude();
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] x);
		expq.push_back(x);
		host.xfer(1'b0, a, 16'h0000);
	endtask
	always @(posedge clock) begin
		if (mgmt_rvalid === 1'b1) begin
			cmp(mgmt_rdata, expq.pop_front());
		end
	end
	initial begin
		void'($urandom(32'h9197));
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(pxl_pkg::ADDR_CTRL_TWO, pxl_pkg::CT_RESET);
		rd(pxl_pkg::ADDR_LOOPBACK, pxl_pkg::LB_RESET);
		rd(5'h1f, 16'h0000);
		// link stays down while diagnostics may be set
		repeat (4) begin
			d = 16'($urandom);
			e = 16'($urandom);
			host.xfer(1'b1, pxl_pkg::ADDR_CTRL_TWO, d);
			host.xfer(1'b1, pxl_pkg::ADDR_LOOPBACK, e);
			host.xfer(1'b1, pxl_pkg::ADDR_RX_ERR, e);
			rd(pxl_pkg::ADDR_CTRL_TWO, d & pxl_pkg::CT_WRITE_MASK);
			rd(pxl_pkg::ADDR_LOOPBACK, e & pxl_pkg::LB_WRITE_MASK);
			cmp(16'(diag_enable), 16'(d[2]));
			cmp(16'(resolve_before_force), 16'(d[15]));
		end
		rd(pxl_pkg::ADDR_RX_ERR, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			detected_mdix <= i[2];
			detected_pair_swap <= 1'($urandom);
			speed <= 2'($urandom_range(2));
			host.xfer(1'b1, pxl_pkg::ADDR_CTRL_TWO, {5'h00, i[1:0], 9'h000});
			repeat (2) @(posedge clock);
			e = 16'(i[1] ? i[2] : i[0]);
			cmp(16'(wiring_mdix), e);
			cmp(16'(tx_pair_sel), e);
			cmp(16'(rx_pair_sel), e ^ 16'h0001);
		end
		for (int s = 0; s < 4; s++) begin
			host.xfer(1'b1, pxl_pkg::ADDR_CTRL_TWO, {1'b0, s[1:0], 13'h0000});
			for (int k = 2; k >= 0; k--) begin
				{crc_err, symbol_err, false_carrier} <= 3'(1 << k);
				@(posedge clock);
			end
			{crc_err, symbol_err, false_carrier} <= 3'h0;
			@(posedge clock);
			rd(pxl_pkg::ADDR_RX_ERR, 16'(1 + s[1]));
			rd(pxl_pkg::ADDR_RX_ERR, 16'h0000);
		end
		// general bit set per loopback kind
		foreach (lbt[j]) begin
			{general_loopback, link_up} <= lbt[j][24:23];
			host.xfer(1'b1, pxl_pkg::ADDR_LOOPBACK, lbt[j][22:7]);
			repeat (2) @(posedge clock);
			e = 16'({mii_loopback, digital_loopback, line_driver_loopback, remote_loopback,
				ext_cable_loopback, tx_suppress, link_status});
			cmp(e, 16'(lbt[j][6:0]));
			// far-end modes need the general bit clear, near-end modes need it set
			d = lbt[j][22:7];
			e = 16'(lbt[j][24] & (d[9] | d[7]) & ~(d[15] | d[12] | d[10]));
			cmp(16'(loopback_setup_error), e);
		end
		repeat (4) @(posedge clock);
		cmp(16'(expq.size()), 16'h0000);
		conclude();
	end
	initial begin
		repeat (3000) @(posedge clock);
		fails++;
		conclude();
	end
endmodule
